// File: src/sab_autobaud.sv
// autobaud detector, register file and escape/flow monitor top
//
// Operation
// - detection runs only while enable bit set
// - done flag set by hardware, cleared by host
// - control bit one gates failure interrupt
// - accept at, AT, a/, A/, repeated a
// - recognise 7N2, 7E1, 7O1 and 8N1 frames
// - start clears failures; failure sets one bit
// - any failure with enable raises interrupt
// - fixed failure bit meaning, bits zero to eight
// - captured pair: first low, second high byte
// - scratch register keeps received bits after failure
// - start bit length counted in 3.9 MHz ticks
// - active and success status bits track detection
// - status parity field none, even, odd
// - word length bit and character match bits
// - eight thresholds and eight divider registers
// - bracketing band selects divider for port
// - thresholds eleven bits, dividers sixteen bits
// - flow control enables: guard, xoff, xon, escape
// - flow flags sticky until host clears them
// - escape char resets to plus, thrice
// - received bytes compared with xon and xoff
// - guard band is register times 20 ms
// - on success program port, enable, self-disable, interrupt
// - host locked out of port configuration meanwhile
// - control bit four requests loopback disable
// - eight rates; detection starts on falling edge
`timescale 1ns/1ps
`default_nettype none
`include "sab_defines.svh"
module sab_autobaud #(
	parameter int GUARD_UNIT_CYC = `SAB_GUARD_MS * `SAB_CLK_KHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`SAB_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic serial_receive_line,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic [15:0] port_divider,
	output logic port_word8,
	output sab_pkg::sab_parity_t port_parity,
	output logic port_load,
	output logic port_enable,
	output logic port_loopback_off,
	output logic port_cfg_lock,
	output logic host_irq
);
	import sab_pkg::*;

	sab_esc_if esc_bus ();

	// ==========================================
	// register storage
	logic [4:0] ctrl_r;
	logic [4:0] ctrl_nxt;
	logic [8:0] fail_r;
	logic [15:0] chars_r;
	logic [8:0] tmp_r;
	logic [8:0] tmp_nxt;
	logic [10:0] bcnt_r;
	logic [10:0] bcnt_nxt;
	logic [3:0] fcc_r;
	logic [7:0] esc_r;
	logic [7:0] xon_r;
	logic [7:0] xoff_r;
	logic [7:0] grd_r;
	logic [15:0] rdata_r;
	logic active_r;
	logic ok_r;
	logic w8_r;
	logic c1_r;
	logic c2_r;
	sab_parity_t par_r;

	// ==========================================
	// detector state
	sab_state_t st_r;
	sab_state_t st_nxt;
	logic [11:0] wait_r;
	logic [11:0] wait_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic sec_r;
	logic sec_nxt;
	logic ev_start;
	logic ev_ok;
	logic ld_c1;
	logic ld_c2;
	logic [8:0] ev_fail;
	logic [2:0] rate_sel;

	// ==========================================
	// port-side outputs
	logic [15:0] pdiv_r;
	logic pw8_r;
	sab_parity_t ppar_r;
	logic pload_r;
	logic pen_r;
	logic plpb_r;
	logic lock_r;
	logic irq_r;

	// ==========================================
	// line synchroniser; only the second stage is looked at
	logic rx_s1_r;
	logic rx_s2_r;
	logic rx_prev_r;
	wire rx = rx_s2_r;
	wire rx_fall = rx_prev_r && !rx;

	// ==========================================
	// 3.9 MHz tick from the 10 MHz clock by a fractional accumulator
	logic [7:0] acc_r;
	wire [7:0] acc_sum = 8'(acc_r + `SAB_TICK_NUM);
	wire tick = acc_sum >= `SAB_TICK_DEN;
	wire [7:0] acc_nxt = tick ? 8'(acc_sum - `SAB_TICK_DEN) : acc_sum;
	wire samp = tick && wait_r == 12'h001;
	wire [11:0] half_bit = {2'h0, bcnt_r[10:1]};
	wire [11:0] full_bit = {1'h0, bcnt_r};

	// ==========================================
	// per-rate thresholds and dividers; band k is [thr k, thr k+1), faster rates lower
	wire [87:0] thr_flat;
	wire [127:0] div_flat;
	logic [7:0] in_band;
	for (genvar gi = 0; gi < 8; gi++) begin : g_rate
		logic [10:0] thr_q;
		logic [15:0] div_q;
		wire wr_thr = reg_wr && reg_addr == 5'(`SAB_A_THR0 + gi);
		wire wr_div = reg_wr && reg_addr == 5'(`SAB_A_DIV0 + gi);
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				thr_q <= `SAB_THR_RST;
				div_q <= `SAB_DIV_RST;
			end else begin
				if (wr_thr) begin
					thr_q <= reg_wdata[10:0];
				end
				if (wr_div) begin
					div_q <= reg_wdata;
				end
			end
		end
		assign thr_flat[gi*11 +: 11] = thr_q;
		assign div_flat[gi*16 +: 16] = div_q;
		if (gi < 7) begin : g_mid
			assign in_band[gi] = bcnt_r >= thr_q && bcnt_r < thr_flat[(gi+1)*11 +: 11];
		end else begin : g_top
			assign in_band[gi] = bcnt_r >= thr_q;
		end
	end

	always_comb begin
		rate_sel = 3'h0;
		for (int k = 0; k < 8; k++) begin
			if (in_band[k]) begin
				rate_sel = 3'(k);
			end
		end
	end
	wire band_hit = |in_band;
	wire too_short = !band_hit || bcnt_r < `SAB_MIN_CNT;

	// ==========================================
	// character classification of the byte being completed
	wire [8:0] chr = {rx, tmp_r[8:1]};
	wire is_a = chr[6:0] == `SAB_CH_LA || chr[6:0] == `SAB_CH_UA;
	wire t_lo = chr[6:0] == `SAB_CH_LT;
	wire t_up = chr[6:0] == `SAB_CH_UT;
	wire is_2nd = t_lo || t_up || chr[6:0] == `SAB_CH_SL;
	wire first_lo = chars_r[5];
	wire mixed = (t_lo && !first_lo) || (t_up && first_lo);
	// bit 7 of each character is data, stop or parity depending on framing;
	// where two framings fit the pair, the earlier one below is taken
	wire b1 = chars_r[7];
	wire b2 = chr[7];
	wire p1 = ^chars_r[6:0];
	wire p2 = ^chr[6:0];
	wire f_8n1 = !b1 && !b2;
	wire f_7n2 = b1 && b2;
	wire f_7e1 = b1 == p1 && b2 == p2;
	wire f_7o1 = b1 != p1 && b2 != p2;
	wire fmt_ok = f_8n1 || f_7n2 || f_7e1 || f_7o1;
	wire sab_parity_t fmt_par = (f_8n1 || f_7n2) ? PAR_NONE : (f_7e1 ? PAR_EVEN : PAR_ODD);

	// ==========================================
	// detection sequence
	always_comb begin
		st_nxt = st_r;
		wait_nxt = wait_r;
		bit_nxt = bit_r;
		tmp_nxt = tmp_r;
		sec_nxt = sec_r;
		bcnt_nxt = bcnt_r;
		ev_start = 1'b0;
		ev_ok = 1'b0;
		ld_c1 = 1'b0;
		ld_c2 = 1'b0;
		ev_fail = 9'h000;
		if (tick && wait_r != 12'h000) begin
			wait_nxt = 12'(wait_r - 12'h001);
		end
		if (!ctrl_r[`SAB_CTL_EN] && st_r != AB_PROG) begin
			st_nxt = AB_IDLE;
		end else begin
			unique case (st_r)
				AB_IDLE: begin
					if (rx_fall) begin
						st_nxt = AB_MEAS;
						bcnt_nxt = 11'h000;
						ev_start = 1'b1;
					end
				end
				AB_MEAS: begin
					if (rx) begin
						if (too_short) begin
							ev_fail[`SAB_F_SHORT] = 1'b1;
						end else begin
							st_nxt = AB_BITS;
							wait_nxt = half_bit;
							bit_nxt = 4'h0;
							tmp_nxt = 9'h000;
							sec_nxt = 1'b0;
						end
					end else if (tick) begin
						if (&bcnt_r) begin
							ev_fail[`SAB_F_OVF] = 1'b1;
						end else begin
							bcnt_nxt = 11'(bcnt_r + 11'h001);
						end
					end
				end
				AB_BITS: begin
					if (samp) begin
						tmp_nxt = chr;
						bit_nxt = 4'(bit_r + 4'h1);
						wait_nxt = full_bit;
						if (bit_r == `SAB_LAST_BIT) begin
							if (!sec_r) begin
								if (!chr[8]) begin
									ev_fail[`SAB_F_C1STOP] = 1'b1;
								end else if (!is_a) begin
									ev_fail[`SAB_F_C1MATCH] = 1'b1;
								end else begin
									ld_c1 = 1'b1;
									st_nxt = AB_GAP;
								end
							end else begin
								if (!chr[8]) begin
									ev_fail[`SAB_F_C2STOP] = 1'b1;
								end else if (is_a) begin
									ld_c1 = 1'b1;
									st_nxt = AB_GAP;
								end else if (!is_2nd) begin
									ev_fail[`SAB_F_C2MATCH] = 1'b1;
								end else if (mixed) begin
									ev_fail[`SAB_F_MIXED] = 1'b1;
								end else if (!fmt_ok) begin
									ev_fail[`SAB_F_FMT] = 1'b1;
								end else begin
									ld_c2 = 1'b1;
									st_nxt = AB_PROG;
								end
							end
						end
					end
				end
				AB_GAP: begin
					if (rx_fall) begin
						st_nxt = AB_START2;
						wait_nxt = half_bit;
					end
				end
				AB_START2: begin
					if (samp) begin
						if (rx) begin
							ev_fail[`SAB_F_C2START] = 1'b1;
						end else begin
							st_nxt = AB_BITS;
							wait_nxt = full_bit;
							bit_nxt = 4'h0;
							tmp_nxt = 9'h000;
							sec_nxt = 1'b1;
						end
					end
				end
				AB_PROG: begin
					ev_ok = 1'b1;
					st_nxt = AB_IDLE;
				end
			endcase
		end
		if (|ev_fail) begin
			st_nxt = AB_IDLE;
		end
	end

	// ==========================================
	// bus decode
	wire wr_ctrl = reg_wr && reg_addr == `SAB_A_CTRL;
	wire [4:0] ctrl_wr = wr_ctrl ? (reg_wdata[4:0] & `SAB_CTL_MASK) : ctrl_r;
	// a completion in the same cycle as a host write still sets done
	always_comb begin
		ctrl_nxt = ctrl_wr;
		if (ev_ok) begin
			ctrl_nxt[`SAB_CTL_DONE] = 1'b1;
			ctrl_nxt[`SAB_CTL_EN] = 1'b0;
		end
	end
	wire fail_irq = |ev_fail && ctrl_r[`SAB_CTL_FIE];
	wire [2:0] ridx = reg_addr[2:0];
	wire sel_thr = reg_addr[4:3] == 2'h2;
	wire sel_div = reg_addr[4:3] == 2'h3;
	wire [15:0] stat_word = {9'h000, active_r, ok_r, par_r, w8_r, c2_r, c1_r};
	wire [15:0] rd_mux =
		sel_thr ? {5'h00, thr_flat[ridx*11 +: 11]} :
		sel_div ? div_flat[ridx*16 +: 16] :
		reg_addr == `SAB_A_CTRL ? {11'h000, ctrl_r} :
		reg_addr == `SAB_A_STAT ? stat_word :
		reg_addr == `SAB_A_FAIL ? {7'h00, fail_r} :
		reg_addr == `SAB_A_CHARS ? chars_r :
		reg_addr == `SAB_A_TMP ? {7'h00, tmp_r} :
		reg_addr == `SAB_A_BCNT ? {5'h00, bcnt_r} :
		reg_addr == `SAB_A_FCCTL ? {12'h000, fcc_r} :
		reg_addr == `SAB_A_FCFLG ? {13'h0000, esc_bus.flags} :
		reg_addr == `SAB_A_ESC ? {8'h00, esc_r} :
		reg_addr == `SAB_A_XON ? {8'h00, xon_r} :
		reg_addr == `SAB_A_XOFF ? {8'h00, xoff_r} :
		reg_addr == `SAB_A_GUARD ? {8'h00, grd_r} :
		16'h0000;

	// ==========================================
	// clocked state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_prev_r <= 1'b1;
			acc_r <= 8'h00;
			st_r <= AB_IDLE;
			wait_r <= 12'h000;
			bit_r <= 4'h0;
			sec_r <= 1'b0;
			tmp_r <= 9'h000;
			bcnt_r <= 11'h000;
			ctrl_r <= 5'h00;
		end else begin
			rx_s1_r <= serial_receive_line;
			rx_s2_r <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
			acc_r <= acc_nxt;
			st_r <= st_nxt;
			wait_r <= wait_nxt;
			bit_r <= bit_nxt;
			sec_r <= sec_nxt;
			tmp_r <= tmp_nxt;
			bcnt_r <= bcnt_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fail_r <= 9'h000;
			chars_r <= 16'h0000;
			active_r <= 1'b0;
			ok_r <= 1'b0;
			w8_r <= 1'b0;
			par_r <= PAR_NONE;
			c1_r <= 1'b0;
			c2_r <= 1'b0;
		end else begin
			fail_r <= ev_start ? 9'h000 : (fail_r | ev_fail);
			if (ld_c1) begin
				chars_r[7:0] <= chr[7:0];
			end
			if (ld_c2) begin
				chars_r[15:8] <= chr[7:0];
				w8_r <= f_8n1;
				par_r <= fmt_par;
			end
			active_r <= ev_start || (active_r && st_nxt != AB_IDLE);
			ok_r <= ev_ok || (ok_r && !ev_start);
			c1_r <= ld_c1 || (c1_r && !ev_start);
			c2_r <= ld_c2 || (c2_r && !ev_start);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pdiv_r <= `SAB_DIV_RST;
			pw8_r <= 1'b0;
			ppar_r <= PAR_NONE;
			pload_r <= 1'b0;
			pen_r <= 1'b0;
			plpb_r <= 1'b0;
			lock_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (ev_ok) begin
				pdiv_r <= div_flat[rate_sel*16 +: 16];
				pw8_r <= w8_r;
				ppar_r <= par_r;
			end
			pload_r <= ev_ok;
			pen_r <= ev_ok || (pen_r && !ev_start);
			plpb_r <= (ev_ok && ctrl_r[`SAB_CTL_LPB]) || (plpb_r && !ev_start);
			lock_r <= st_nxt == AB_PROG || ev_ok;
			irq_r <= ev_ok || fail_irq;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fcc_r <= 4'h0;
			esc_r <= `SAB_ESC_RST;
			xon_r <= `SAB_CHR_RST;
			xoff_r <= `SAB_CHR_RST;
			grd_r <= `SAB_GUARD_RST;
			rdata_r <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == `SAB_A_FCCTL) begin
				fcc_r <= reg_wdata[3:0];
			end
			if (reg_wr && reg_addr == `SAB_A_ESC) begin
				esc_r <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == `SAB_A_XON) begin
				xon_r <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == `SAB_A_XOFF) begin
				xoff_r <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == `SAB_A_GUARD) begin
				grd_r <= reg_wdata[7:0];
			end
			rdata_r <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// ==========================================
	// escape and flow-control detector
	assign esc_bus.byte_valid = rx_byte_valid;
	assign esc_bus.byte_data = rx_byte;
	assign esc_bus.ctrl = fcc_r;
	assign esc_bus.esc_char = esc_r;
	assign esc_bus.xon_char = xon_r;
	assign esc_bus.xoff_char = xoff_r;
	assign esc_bus.guard = grd_r;
	// write one to clear
	assign esc_bus.clr = (reg_wr && reg_addr == `SAB_A_FCFLG) ? reg_wdata[2:0] : 3'h0;

	sab_esc_detect #(
		.GUARD_UNIT_CYC(GUARD_UNIT_CYC)
	) u_esc (
		.clk(clk),
		.reset_n(reset_n),
		.bus(esc_bus.det)
	);

	assign reg_rdata = rdata_r;
	assign port_divider = pdiv_r;
	assign port_word8 = pw8_r;
	assign port_parity = ppar_r;
	assign port_load = pload_r;
	assign port_enable = pen_r;
	assign port_loopback_off = plpb_r;
	assign port_cfg_lock = lock_r;
	assign host_irq = irq_r;
endmodule
`default_nettype wire

// File: src/sab_defines.svh
// register map, field positions, reset values and timing constants of the autobaud monitor
`ifndef SAB_DEFINES_SVH
`define SAB_DEFINES_SVH

`define SAB_AW 5
`define SAB_A_CTRL 5'h00
`define SAB_A_STAT 5'h01
`define SAB_A_FAIL 5'h02
`define SAB_A_CHARS 5'h03
`define SAB_A_TMP 5'h04
`define SAB_A_BCNT 5'h05
`define SAB_A_FCCTL 5'h06
`define SAB_A_FCFLG 5'h07
`define SAB_A_ESC 5'h08
`define SAB_A_XON 5'h09
`define SAB_A_XOFF 5'h0a
`define SAB_A_GUARD 5'h0b
`define SAB_A_THR0 5'h10
`define SAB_A_DIV0 5'h18

`define SAB_CTL_EN 0
`define SAB_CTL_FIE 1
`define SAB_CTL_DONE 2
`define SAB_CTL_LPB 4
`define SAB_CTL_MASK 5'h17

`define SAB_F_SHORT 0
`define SAB_F_OVF 1
`define SAB_F_C1MATCH 2
`define SAB_F_C1STOP 3
`define SAB_F_C2START 4
`define SAB_F_C2MATCH 5
`define SAB_F_C2STOP 6
`define SAB_F_MIXED 7
`define SAB_F_FMT 8

`define SAB_FC_ESC 0
`define SAB_FC_XON 1
`define SAB_FC_XOFF 2
`define SAB_FC_GUARD 3

`define SAB_THR_RST 11'h000
`define SAB_DIV_RST 16'h0000
`define SAB_ESC_RST 8'h2b
`define SAB_CHR_RST 8'h00
`define SAB_GUARD_RST 8'h01

`define SAB_CH_LA 7'h61
`define SAB_CH_UA 7'h41
`define SAB_CH_LT 7'h74
`define SAB_CH_UT 7'h54
`define SAB_CH_SL 7'h2f

`define SAB_TICK_NUM 8'h27
`define SAB_TICK_DEN 8'h64
`define SAB_MIN_CNT 11'h002
`define SAB_LAST_BIT 4'h8
`define SAB_ESC_RUN 2'h3
`define SAB_CLK_KHZ 10000
`define SAB_GUARD_MS 20

`endif

// File: src/sab_pkg.sv
// shared types of the autobaud and escape monitor
package sab_pkg;
	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} sab_parity_t;
	typedef enum logic [2:0] {AB_IDLE, AB_MEAS, AB_BITS, AB_GAP, AB_START2, AB_PROG} sab_state_t;
endpackage

// File: src/sab_esc_if.sv
// carrier between the autobaud top and the escape/flow detector
`timescale 1ns/1ps
`default_nettype none
interface sab_esc_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic [3:0] ctrl;
	logic [7:0] esc_char;
	logic [7:0] xon_char;
	logic [7:0] xoff_char;
	logic [7:0] guard;
	logic [2:0] clr;
	logic [2:0] flags;
	modport host (output byte_valid, byte_data, ctrl, esc_char, xon_char, xoff_char, guard, clr, input flags);
	modport det (input byte_valid, byte_data, ctrl, esc_char, xon_char, xoff_char, guard, clr, output flags);
endinterface
`default_nettype wire

// File: src/sab_esc_detect.sv
// escape sequence and xon/pause_character detector with guard timer
`timescale 1ns/1ps
`default_nettype none
`include "sab_defines.svh"
module sab_esc_detect #(
	parameter int GUARD_UNIT_CYC = `SAB_GUARD_MS * `SAB_CLK_KHZ
) (
	input wire logic clk,
	input wire logic reset_n,
	sab_esc_if.det bus
);
	import sab_pkg::*;

	localparam int UW = $clog2(GUARD_UNIT_CYC + 1);

	logic [UW-1:0] unit_r;
	logic [7:0] idle_r;
	logic [1:0] run_r;
	logic [2:0] flag_r;

	// ==========================================
	// guard timing: idle time counted in 20 ms units since the last byte
	wire unit_tick = unit_r == UW'(GUARD_UNIT_CYC - 1);
	wire quiet = !bus.ctrl[`SAB_FC_GUARD] || idle_r >= bus.guard;
	wire is_esc = bus.ctrl[`SAB_FC_ESC] && bus.byte_data == bus.esc_char;
	wire hit_xon = bus.byte_valid && bus.ctrl[`SAB_FC_XON] && bus.byte_data == bus.xon_char;
	wire hit_xoff = bus.byte_valid && bus.ctrl[`SAB_FC_XOFF] && bus.byte_data == bus.xoff_char;
	// third escape char only counts once the trailing guard has passed quietly
	wire hit_esc = !bus.byte_valid && run_r == `SAB_ESC_RUN && quiet;
	// a first escape char needs a quiet leading guard; a fourth one breaks the run
	wire run_ok = is_esc && (run_r != 2'h0 || quiet) && run_r != `SAB_ESC_RUN;
	wire [1:0] run_nxt = bus.byte_valid ? (run_ok ? 2'(run_r + 2'h1) : 2'h0) : (hit_esc ? 2'h0 : run_r);
	wire [2:0] flag_set = {hit_xoff, hit_xon, hit_esc};

	// ==========================================
	// state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			unit_r <= '0;
			idle_r <= 8'h00;
			run_r <= 2'h0;
			flag_r <= 3'h0;
		end else begin
			unit_r <= (bus.byte_valid || unit_tick) ? '0 : UW'(unit_r + 1'b1);
			idle_r <= bus.byte_valid ? 8'h00 : ((unit_tick && idle_r != 8'hff) ? 8'(idle_r + 8'h01) : idle_r);
			run_r <= run_nxt;
			// set wins over a clear in the same cycle
			flag_r <= flag_set | (flag_r & ~bus.clr);
		end
	end

	assign bus.flags = flag_r;
endmodule
`default_nettype wire

// File: dv/sab_terminal.sv
// data terminal model driving framed characters onto the receive line
`timescale 1ns/1ps
`default_nettype none
module sab_terminal (
	input wire logic clk,
	output logic line
);
	// the line rests high between frames, as an idle asynchronous link does
	initial line = 1'b1;
	// start bit low, eight data bits lsb first, one stop bit: 8n1 frames only
	task automatic send(input logic [7:0] c, input int per);
		logic [9:0] frame;
		frame = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line <= frame[i];
			repeat (per - 1) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// File: dv/sab_autobaud_checker.sv
// concurrent checks on the autobaud monitor top ports
`timescale 1ns/1ps
`default_nettype none
`include "sab_defines.svh"
module sab_autobaud_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`SAB_AW-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire sab_pkg::sab_parity_t port_parity,
	input wire logic port_load,
	input wire logic port_enable,
	input wire logic port_loopback_off,
	input wire logic port_cfg_lock,
	input wire logic host_irq
);
	import sab_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// port programming
	AST_LOAD_IRQ_EN: assert property (port_load |-> host_irq && port_enable)
		else $error("load without irq or enable");
	AST_LOAD_PULSE: assert property (port_load |=> !port_load && port_enable)
		else $error("load longer than one cycle");
	AST_LOCK_AROUND: assert property (port_load |-> port_cfg_lock && $past(port_cfg_lock))
		else $error("config lock missing around load");
	AST_LOCK_LEAD: assert property ($rose(port_cfg_lock) |=> port_load)
		else $error("lock not followed by load");
	AST_LPB_WITH_LOAD: assert property ($rose(port_loopback_off) |-> port_load)
		else $error("loopback off without load");
	AST_PARITY_CODE: assert property (port_parity inside {PAR_NONE, PAR_EVEN, PAR_ODD})
		else $error("invalid parity code");
	// ==========================================
	// reserved bits of read data
	AST_STAT_RSVD: assert property (reg_rd && reg_addr == `SAB_A_STAT
		|=> reg_rdata[15:7] == 9'h000 && reg_rdata[4:3] != 2'h3)
		else $error("status reserved or parity bad");
	AST_THR_RSVD: assert property (reg_rd && reg_addr[4:3] == 2'h2 |=> reg_rdata[15:11] == 5'h00)
		else $error("threshold upper bits set");
	AST_FCCTL_RSVD: assert property (reg_rd && reg_addr == `SAB_A_FCCTL |=> reg_rdata[15:4] == 12'h000)
		else $error("flow control reserved bits set");
	AST_FLG_RSVD: assert property (reg_rd && reg_addr == `SAB_A_FCFLG |=> reg_rdata[15:3] == 13'h0000)
		else $error("flow flag reserved bits set");
endmodule
`default_nettype wire

// File: dv/sab_autobaud_tb_top.sv
// self-checking bench for the autobaud and escape monitor
`timescale 1ns/1ps
`default_nettype none
`include "sab_defines.svh"
module sab_autobaud_tb_top;
	import sab_pkg::*;
	localparam int PER = 100;
	logic clk, reset_n, reg_wr, reg_rd, rx_byte_valid, serial_receive_line;
	logic [`SAB_AW-1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, port_divider, v;
	logic [7:0] rx_byte;
	logic port_word8, port_load, port_enable, port_loopback_off, port_cfg_lock, host_irq;
	sab_parity_t port_parity;
	int fail_count, num_checks, irq_cnt, load_cnt;
	// ==========================================
	// design and terminal
	sab_autobaud #(.GUARD_UNIT_CYC(20)) dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_receive_line(serial_receive_line), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.port_divider(port_divider), .port_word8(port_word8), .port_parity(port_parity),
		.port_load(port_load), .port_enable(port_enable), .port_loopback_off(port_loopback_off),
		.port_cfg_lock(port_cfg_lock), .host_irq(host_irq));
	sab_terminal term_u (.clk(clk), .line(serial_receive_line));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (port_load === 1'b1) load_cnt++;
		if (host_irq === 1'b1) irq_cnt++;
	end
	// ==========================================
	// bus and compare tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe; taken just after that edge
	task automatic fetch(input logic [4:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		fetch(a);
		chk(v, exp);
	endtask
	task automatic put_byte(input logic [7:0] b);
		@(posedge clk);
		rx_byte_valid <= 1'b1;
		rx_byte <= b;
		@(posedge clk);
		rx_byte_valid <= 1'b0;
	endtask
	task automatic wait_loads(input int n);
		int k;
		k = 0;
		while (load_cnt < n && k < 20000) begin
			@(posedge clk);
			k++;
		end
		if (load_cnt < n) begin
			fail_count++;
			$display("BAD t=%0t load timeout got=%h exp=%h", $time, load_cnt, n);
			give_verdict();
		end
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset_and_tables;
		rd(`SAB_A_CTRL, 16'h0000);
		rd(`SAB_A_ESC, 16'h002b);
		rd(`SAB_A_GUARD, 16'h0001);
		rd(5'h0c, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			wr(5'(`SAB_A_THR0 + k), 16'(5 + 10 * k));
			wr(5'(`SAB_A_DIV0 + k), 16'(16'h0100 + k));
		end
		wr(5'h17, 16'hffff);
		rd(5'h17, 16'h07ff);
		rd(5'h1a, 16'h0102);
	endtask
	task automatic t_disabled;
		term_u.send(8'h61, PER);
		term_u.send(8'h74, PER);
		chk(16'(load_cnt), 16'h0000);
		rd(`SAB_A_STAT, 16'h0000);
	endtask
	task automatic t_success;
		wr(`SAB_A_CTRL, 16'h0013);
		term_u.send(8'h61, PER);
		term_u.send(8'h41, PER);
		term_u.send(8'h54, PER);
		wait_loads(1);
		chk(port_divider, 16'h0103);
		chk({13'h0, port_word8, port_parity}, 16'h0004);
		chk({15'h0, port_loopback_off}, 16'h0001);
		chk(16'(irq_cnt), 16'h0001);
		rd(`SAB_A_CTRL, 16'h0016);
		rd(`SAB_A_STAT, 16'h0027);
		rd(`SAB_A_CHARS, 16'h5441);
		fetch(`SAB_A_BCNT);
		// the measured count may land a tick either side of 39 after synchronising
		chk({15'h0, v >= 16'h0026 && v <= 16'h0028}, 16'h0001);
	endtask
	task automatic t_failures;
		wr(`SAB_A_CTRL, 16'h0003);
		// a first data bit of one keeps the start bit measurable
		term_u.send(8'h79, PER);
		rd(`SAB_A_FAIL, 16'h0004);
		rd(`SAB_A_TMP, 16'h0179);
		chk(16'(irq_cnt), 16'h0002);
		rd(`SAB_A_CTRL, 16'h0003);
		term_u.send(8'h61, PER);
		term_u.send(8'h54, PER);
		rd(`SAB_A_FAIL, 16'h0080);
		wr(`SAB_A_CTRL, 16'h0001);
		term_u.send(8'h79, PER);
		rd(`SAB_A_FAIL, 16'h0004);
		chk(16'(irq_cnt), 16'h0003);
	endtask
	// 7-bit framings: bit 7 of each byte carries parity or the second stop bit
	task automatic t_parity;
		wr(`SAB_A_CTRL, 16'h0001);
		term_u.send(8'he1, PER);
		term_u.send(8'h74, PER);
		wait_loads(2);
		chk({13'h0, port_word8, port_parity}, 16'h0001);
		chk({15'h0, port_loopback_off}, 16'h0000);
		rd(`SAB_A_STAT, 16'h002b);
		rd(`SAB_A_CHARS, 16'h74e1);
		wr(`SAB_A_CTRL, 16'h0001);
		term_u.send(8'h61, PER);
		term_u.send(8'hf4, PER);
		wait_loads(3);
		chk({13'h0, port_word8, port_parity}, 16'h0002);
		wr(`SAB_A_CTRL, 16'h0001);
		term_u.send(8'he1, PER);
		term_u.send(8'hf4, PER);
		wait_loads(4);
		chk({13'h0, port_word8, port_parity}, 16'h0000);
	endtask
	task automatic t_flow;
		wr(`SAB_A_XON, 16'h0011);
		wr(`SAB_A_XOFF, 16'h0013);
		wr(`SAB_A_FCCTL, 16'h0007);
		repeat (3) put_byte(8'h2b);
		put_byte(8'h11);
		put_byte(8'h13);
		rd(`SAB_A_FCFLG, 16'h0007);
		wr(`SAB_A_FCFLG, 16'h0007);
		rd(`SAB_A_FCFLG, 16'h0000);
		wr(`SAB_A_FCCTL, 16'h0000);
		put_byte(8'h11);
		rd(`SAB_A_FCFLG, 16'h0000);
	endtask
	task automatic t_guard;
		wr(`SAB_A_FCCTL, 16'h0009);
		repeat (60) @(posedge clk);
		repeat (3) put_byte(8'h2b);
		repeat (60) @(posedge clk);
		rd(`SAB_A_FCFLG, 16'h0001);
		wr(`SAB_A_FCFLG, 16'h0001);
		repeat (60) @(posedge clk);
		repeat (3) put_byte(8'h2b);
		put_byte(8'h78);
		repeat (60) @(posedge clk);
		rd(`SAB_A_FCFLG, 16'h0000);
	endtask
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = 16'h0000;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		fail_count = 0;
		num_checks = 0;
		irq_cnt = 0;
		load_cnt = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_reset_and_tables();
		t_disabled();
		t_success();
		t_failures();
		t_parity();
		t_flow();
		t_guard();
		give_verdict();
	end
endmodule
bind sab_autobaud sab_autobaud_checker chk_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_parity(port_parity), .port_load(port_load),
	.port_enable(port_enable), .port_loopback_off(port_loopback_off),
	.port_cfg_lock(port_cfg_lock), .host_irq(host_irq));
`default_nettype wire
